//--- dms_pkg.sv
// Purpose: shared constants and types for the drive mode select and auto setup block
// Assumes: 32-bit AHB-Lite register bus, 20 MHz hclk, 12-bit analog level input
// Notes:   register offsets are byte addresses of aligned words
`default_nettype none

package dms_pkg;

    // register map (byte offsets)
    localparam logic [7:0]  OFF_OPMODE   = 8'h00;
    localparam logic [7:0]  OFF_CTLWORD  = 8'h04;
    localparam logic [7:0]  OFF_STATWORD = 8'h08;
    localparam logic [7:0]  OFF_SPECIAL  = 8'h0C;
    localparam logic [7:0]  OFF_PROGCTL  = 8'h10;
    localparam logic [7:0]  OFF_VELTGT   = 8'h14;
    localparam logic [7:0]  OFF_SCALE    = 8'h18;
    localparam logic [7:0]  OFF_PARAMS   = 8'h1C;

    // operating mode codes
    localparam logic [7:0]  OPM_AUTOSETUP = 8'hFE;
    localparam logic [7:0]  OPM_VELOCITY  = 8'h02;
    localparam logic [7:0]  OPM_CLKDIR    = 8'hF7;

    // control word and status word fields
    localparam int          CW_OMS_BIT    = 4;
    localparam logic [3:0]  CW_ENABLE_OP  = 4'hF;
    localparam int          SW_OPEN_BIT   = 2;
    localparam int          SW_IDX_BIT    = 10;
    localparam int          SW_DONE_BIT   = 12;

    // special mode register fields
    localparam int          SP_ACTIVE_BIT = 4;
    localparam int          SP_CLOSED_BIT = 5;
    localparam int          SP_COORD_BIT  = 6;
    localparam int          SP_CFGEN_BIT  = 8;

    // coding switch fields
    localparam int          SWC_CLOSED_BIT = 3;
    localparam int          SWC_ANA_BIT    = 2;
    localparam int          SWC_SUB_BIT    = 1;
    localparam int          SWC_ODD_BIT    = 0;
    localparam logic [3:0]  SW_SHIP        = 4'h1;

    // reset values
    localparam logic        SPEC_EN_RST   = 1'b1;
    localparam logic [15:0] SCALE_RST     = 16'h0001;

    // speeds in rpm
    localparam logic [9:0]  RPM_TEST      = 10'd30;
    localparam logic [9:0]  RPM_MAX_HI    = 10'd1000;
    localparam logic [9:0]  RPM_MAX_LO    = 10'd100;

    // analog scaling
    localparam int          ADC_W         = 12;
    localparam int          ANA_FS_MV     = 10000;
    localparam int          DZ_MV         = 20;
    localparam int          DZ_CNT        = (DZ_MV * (1 << ADC_W) + ANA_FS_MV - 1) / ANA_FS_MV;

    typedef enum logic {AS_IDLE, AS_RUN} dms_as_st_t;

    // operator side inputs
    typedef struct packed {
        logic             enable;
        logic             step_clk;
        logic             dir;
        logic [ADC_W-1:0] level;
    } dms_op_in_t;

    // result of the measurement engine
    typedef struct packed {
        logic        done;
        logic        ok;
        logic        index_found;
        logic [31:0] params;
    } dms_setup_res_t;

    // decoded special mode
    typedef struct packed {
        logic active;
        logic analog;
        logic joystick;
        logic slow;
        logic test;
        logic test_ccw;
    } dms_spmode_t;

endpackage

`default_nettype wire

//--- dms_vel_calc.sv
// Purpose: converts the analog level or test run into a target velocity in rpm
// Assumes: level is synchronous to hclk, full scale is 2**ADC_W-1
// Notes:   output is registered; zero whenever enable is low
`default_nettype none

module dms_vel_calc
    import dms_pkg::*;
#(
    parameter int LVL_W = ADC_W
) (
    // clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // mode and operator inputs
    input  wire dms_pkg::dms_spmode_t spm,
    input  wire logic               enable,
    input  wire logic               dir,
    input  wire logic [LVL_W-1:0]   level,
    // scaling factor
    input  wire logic [15:0]        num,
    input  wire logic [15:0]        den,
    // result
    output logic [31:0]             vel
);
    import dms_pkg::*;

    localparam logic [LVL_W:0] CENTER = (LVL_W+1)'(1 << (LVL_W - 1));
    localparam logic [LVL_W:0] FULL   = (LVL_W+1)'((1 << LVL_W) - 1);
    localparam logic [LVL_W:0] DZ     = (LVL_W+1)'(DZ_CNT);

    typedef struct packed {
        logic [31:0] vel;
    } dms_vel_st_t;

    dms_vel_st_t s_q;
    dms_vel_st_t s_d;

    always_comb begin
        logic [LVL_W:0] mag;
        logic [LVL_W:0] full;
        logic           neg;
        logic [9:0]     vmax;
        logic [15:0]    dsafe;
        logic [47:0]    prod;
        logic [47:0]    quo;
        mag   = '0;
        full  = FULL;
        neg   = 1'b0;
        vmax  = spm.slow ? RPM_MAX_LO : RPM_MAX_HI;
        dsafe = (den == 16'h0000) ? 16'h0001 : den;
        prod  = '0;
        quo   = '0;
        s_d   = s_q;
        if (spm.joystick) begin
            full = CENTER;
            if ({1'b0, level} >= CENTER) begin
                mag = {1'b0, level} - CENTER;
                neg = 1'b0;
            end else begin
                mag = CENTER - {1'b0, level};
                neg = 1'b1;
            end
        end else begin
            mag = {1'b0, level};
            neg = dir;
        end
        if (mag <= DZ) begin
            mag = '0;
        end
        prod = 48'(mag) * 48'(vmax) * 48'(num);
        quo  = prod / (48'(full) * 48'(dsafe));
        if (!spm.active || !enable) begin
            s_d.vel = '0;
        end else if (spm.test) begin
            s_d.vel = spm.test_ccw ? -32'(RPM_TEST) : 32'(RPM_TEST);
        end else if (spm.analog) begin
            s_d.vel = neg ? -quo[31:0] : quo[31:0];
        end else begin
            s_d.vel = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign vel = s_q.vel;

endmodule // dms_vel_calc

`default_nettype wire

//--- dms_drive_mode.sv
// Purpose: mode selection, special drive modes and auto setup sequencing
// Assumes: AHB-Lite slave with zero wait states, inputs synchronous to hclk
// Notes:   coding switch and special enable are captured once after reset
`default_nettype none

module dms_drive_mode
    import dms_pkg::*;
(
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // straps
    input  wire logic [3:0]             sw_val,
    input  wire logic                   spec_cfg_en,
    // operator inputs
    input  wire dms_pkg::dms_op_in_t    op_in,
    // measurement engine
    input  wire dms_pkg::dms_setup_res_t setup_res,
    output logic                        setup_run,
    output logic                        store_req,
    // drive outputs
    output logic                        op_enabled,
    output logic [7:0]                  op_mode,
    output logic                        closed_loop,
    output logic                        step_clk_out,
    output logic                        step_dir_out,
    output logic [31:0]                 vel_target
);
    import dms_pkg::*;

    typedef struct packed {
        logic             dph;
        logic             dwr;
        logic [7:0]       daddr;
        logic [31:0]      hrdata;
        logic             hready;
        logic [7:0]       opmode;
        logic [15:0]      ctl;
        logic             prog;
        logic [15:0]      num;
        logic [15:0]      den;
        logic             init;
        logic [3:0]       sw;
        logic             spec_en;
        logic             oms_prev;
        dms_as_st_t       as_st;
        logic             done;
        logic             idx;
        logic [31:0]      params;
        logic             store;
        logic             run;
        logic             coord_bad;
        logic             op_en;
        logic [7:0]       op_mode;
        logic             closed;
        logic             step_clk;
        logic             step_dir;
    } dms_state_t;

    dms_state_t  s_q;
    dms_state_t  s_d;
    dms_spmode_t spm;
    logic [31:0] vel;

    // decoded special mode, constant after the capture
    always_comb begin
        spm          = '0;
        spm.active   = s_q.init && s_q.spec_en;
        spm.analog   = s_q.sw[SWC_ANA_BIT];
        spm.joystick = s_q.sw[SWC_ANA_BIT] && s_q.sw[SWC_SUB_BIT];
        spm.slow     = s_q.sw[SWC_ODD_BIT];
        spm.test     = !s_q.sw[SWC_ANA_BIT] && s_q.sw[SWC_SUB_BIT];
        spm.test_ccw = s_q.sw[SWC_ODD_BIT];
    end

    dms_vel_calc #(
        .LVL_W (ADC_W)
    ) u_vel (
        .hclk    (hclk),
        .hresetn (hresetn),
        .spm     (spm),
        .enable  (op_in.enable),
        .dir     (op_in.dir),
        .level   (op_in.level),
        .num     (s_q.num),
        .den     (s_q.den),
        .vel     (vel)
    );

    always_comb begin
        logic        oms_rise;
        logic [15:0] stat;
        logic [31:0] rd;
        oms_rise = 1'b0;
        stat     = '0;
        rd       = '0;
        s_d      = s_q;
        s_d.store = 1'b0;

        // one-time capture after reset release
        if (!s_q.init) begin
            s_d.init    = 1'b1;
            s_d.sw      = sw_val;
            s_d.spec_en = spec_cfg_en;
        end

        // data phase writes
        if (s_q.dph && s_q.dwr) begin
            case (s_q.daddr)
                OFF_OPMODE: begin
                    s_d.opmode = hwdata[7:0];
                end
                OFF_CTLWORD: begin
                    s_d.ctl = hwdata[15:0];
                end
                OFF_PROGCTL: begin
                    s_d.prog = hwdata[0];
                end
                OFF_SCALE: begin
                    s_d.num = hwdata[15:0];
                    s_d.den = hwdata[31:16];
                end
                default: begin
                end
            endcase
        end

        // power state and operating mode
        if (spm.active) begin
            s_d.op_en  = op_in.enable;
            s_d.closed = s_q.sw[SWC_CLOSED_BIT];
            if (s_q.sw[SWC_ANA_BIT]) begin
                s_d.op_mode = OPM_VELOCITY;
            end else begin
                s_d.op_mode = OPM_CLKDIR;
            end
            if (!s_q.sw[SWC_ANA_BIT] && !s_q.sw[SWC_SUB_BIT]) begin
                s_d.step_clk = op_in.step_clk && op_in.enable;
                s_d.step_dir = op_in.dir;
            end else begin
                s_d.step_clk = 1'b0;
                s_d.step_dir = 1'b0;
            end
        end else begin
            s_d.op_en    = (s_d.ctl[3:0] == CW_ENABLE_OP);
            s_d.closed   = 1'b0;
            s_d.op_mode  = s_d.opmode;
            s_d.step_clk = 1'b0;
            s_d.step_dir = 1'b0;
        end

        // auto setup sequence
        oms_rise     = s_d.ctl[CW_OMS_BIT] && !s_q.oms_prev;
        s_d.oms_prev = s_d.ctl[CW_OMS_BIT];
        case (s_q.as_st)
            AS_IDLE: begin
                if (!spm.active && s_q.opmode == OPM_AUTOSETUP && s_q.op_en && oms_rise
                    && !s_q.prog) begin
                    s_d.as_st = AS_RUN;
                    s_d.run   = 1'b1;
                    s_d.done  = 1'b0;
                    s_d.idx   = 1'b0;
                end
            end
            AS_RUN: begin
                if (setup_res.done) begin
                    s_d.as_st     = AS_IDLE;
                    s_d.run       = 1'b0;
                    s_d.done      = 1'b1;
                    s_d.idx       = setup_res.index_found;
                    s_d.coord_bad = 1'b1;
                    if (setup_res.ok) begin
                        s_d.params = setup_res.params;
                        s_d.store  = 1'b1;
                    end
                end else if (!s_q.op_en || s_q.opmode != OPM_AUTOSETUP) begin
                    s_d.as_st = AS_IDLE;
                    s_d.run   = 1'b0;
                end
            end
            default: begin
                s_d.as_st = AS_IDLE;
                s_d.run   = 1'b0;
            end
        endcase

        // status word
        stat[SW_OPEN_BIT] = s_d.op_en;
        stat[SW_IDX_BIT]  = s_d.idx;
        stat[SW_DONE_BIT] = s_d.done;

        // read mux sees writes of the current data phase
        case (haddr[7:0])
            OFF_OPMODE:   rd = {24'h000000, s_d.opmode};
            OFF_CTLWORD:  rd = {16'h0000, s_d.ctl};
            OFF_STATWORD: rd = {16'h0000, stat};
            OFF_SPECIAL: begin
                rd[3:0]           = s_d.sw;
                rd[SP_ACTIVE_BIT] = spm.active;
                rd[SP_CLOSED_BIT] = s_d.closed;
                rd[SP_COORD_BIT]  = s_d.coord_bad;
                rd[SP_CFGEN_BIT]  = s_d.spec_en;
            end
            OFF_PROGCTL:  rd = {31'h00000000, s_d.prog};
            OFF_VELTGT:   rd = vel;
            OFF_SCALE:    rd = {s_d.den, s_d.num};
            OFF_PARAMS:   rd = s_d.params;
            default:      rd = 32'h00000000;
        endcase

        // address phase
        s_d.dph    = hsel && htrans[1] && hready;
        s_d.dwr    = hwrite;
        s_d.daddr  = haddr[7:0];
        s_d.hready = 1'b1;
        if (hsel && htrans[1] && hready && !hwrite) begin
            s_d.hrdata = rd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q         <= '0;
            s_q.hready  <= 1'b1;
            s_q.num     <= SCALE_RST;
            s_q.den     <= SCALE_RST;
            s_q.sw      <= SW_SHIP;
            s_q.spec_en <= SPEC_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata       = s_q.hrdata;
    assign hreadyout    = s_q.hready;
    assign hresp        = 1'b0;
    assign setup_run    = s_q.run;
    assign store_req    = s_q.store;
    assign op_enabled   = s_q.op_en;
    assign op_mode      = s_q.op_mode;
    assign closed_loop  = s_q.closed;
    assign step_clk_out = s_q.step_clk;
    assign step_dir_out = s_q.step_dir;
    assign vel_target   = vel;

endmodule // dms_drive_mode

`default_nettype wire

//--- dms_drive_mode_assertions.sv
// Purpose: port checks for the drive mode select block
// Assumes: one hclk domain, hresetn async active low
// Notes:   bound to the top module from the bench file
`default_nettype none

module dms_drive_mode_chk
    import dms_pkg::*;
(
    // clock and reset
    input wire logic                    hclk,
    input wire logic                    hresetn,
    // operator and engine side
    input wire dms_pkg::dms_op_in_t     op_in,
    input wire dms_pkg::dms_setup_res_t setup_res,
    // block outputs
    input wire logic                    setup_run,
    input wire logic                    store_req,
    input wire logic                    op_enabled,
    input wire logic [7:0]              op_mode,
    input wire logic                    closed_loop,
    input wire logic                    step_clk_out,
    input wire logic                    step_dir_out,
    input wire logic [31:0]             vel_target
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] age_q;
    // edges since reset release, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    clk_follow_a: assert property (step_clk_out |-> $past(op_in.step_clk && op_in.enable))
        else $error("step clock out without enabled input clock");
    dir_follow_a: assert property (step_dir_out |-> $past(op_in.dir))
        else $error("step direction out without direction input");
    enable_follow_a: assert property ((op_mode == OPM_CLKDIR && $past(op_mode) == OPM_CLKDIR
        && $past(op_mode, 2) == OPM_CLKDIR) |-> op_enabled == $past(op_in.enable))
        else $error("power state not following enable input");
    run_start_a: assert property ($rose(setup_run) |-> $past(op_enabled) && $past(op_mode) == OPM_AUTOSETUP)
        else $error("setup started without enabled setup mode");
    run_end_a: assert property (setup_run && setup_res.done |=> !setup_run)
        else $error("setup still running after done");
    store_cause_a: assert property (store_req |-> $past(setup_res.done && setup_res.ok && setup_run))
        else $error("store request without successful setup");
    store_pulse_a: assert property (store_req |=> !store_req)
        else $error("store request longer than one cycle");
    vel_idle_a: assert property (!$past(op_in.enable) |-> vel_target == 32'h0)
        else $error("velocity target nonzero while disabled");
    mode_hold_a: assert property (age_q == 2'h3 |-> $stable(closed_loop))
        else $error("loop mode changed without restart");
    cover property ($rose(setup_run));
    cover property (store_req);
    cover property ($rose(step_clk_out));
endmodule // dms_drive_mode_chk

`default_nettype wire

//--- dms_op_src.sv
// Purpose: operator side model driving enable, clock, direction, level
// Assumes: changes land right after rising hclk edges
// Notes:   step clock rests low outside bursts
`default_nettype none

module dms_op_src
    import dms_pkg::*;
(
    // clock
    input wire logic            hclk,
    // operator lines
    output var dms_pkg::dms_op_in_t op_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial op_in = '0;
    // levels hold until the next call
    task automatic set_in(input logic en, input logic d, input logic [ADC_W-1:0] lvl);
        @(posedge hclk);
        op_in.enable <= en;
        op_in.dir    <= d;
        op_in.level  <= lvl;
    endtask
    // pulses two cycles high, two low
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge hclk);
            op_in.step_clk <= 1'h1;
            repeat (2) @(posedge hclk);
            op_in.step_clk <= 1'h0;
        end
    endtask
endmodule // dms_op_src

`default_nettype wire

//--- test_dms_drive_mode.sv
// Purpose: self-checking bench for the drive mode select block
// Assumes: hclk 20 MHz, zero wait AHB-Lite slave
// Notes:   each switch mode is entered through a fresh reset
`default_nettype none

module test_dms_drive_mode
    import dms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           hclk = 1'h0;
    logic           hresetn = 1'h0;
    logic           hsel = 1'h0;
    logic [31:0]    haddr = 32'h0;
    logic [1:0]     htrans = 2'h0;
    logic           hwrite = 1'h0;
    logic [31:0]    hwdata = 32'h0;
    logic [3:0]     sw_val = SW_SHIP;
    logic           spec_cfg_en = 1'h1;
    dms_setup_res_t setup_res = '0;
    dms_op_in_t     op_in;
    logic [31:0]    hrdata, vel_target, rd, p;
    logic [7:0]     op_mode;
    logic           hreadyout, hresp, setup_run, store_req, op_enabled, closed_loop, step_clk_out, step_dir_out;
    int             mismatches = 0, check_count = 0, steps = 0, stores = 0, num = 1, den = 1;

    always #25 hclk = ~hclk;
    always @(posedge step_clk_out) steps++;
    always @(posedge hclk) if (store_req === 1'h1) stores++;

    dms_drive_mode dms_drive_mode_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sw_val(sw_val), .spec_cfg_en(spec_cfg_en), .op_in(op_in),
        .setup_res(setup_res), .setup_run(setup_run), .store_req(store_req), .op_enabled(op_enabled),
        .op_mode(op_mode), .closed_loop(closed_loop), .step_clk_out(step_clk_out),
        .step_dir_out(step_dir_out), .vel_target(vel_target));
    dms_op_src dms_op_src_inst (.hclk(hclk), .op_in(op_in));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 50);
        if (n == 50) mismatches++;
    endtask
    // one single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        check(rd & m, e);
        check({30'h0, hreadyout, hresp}, 32'h2);
    endtask
    task automatic restart(input logic [3:0] s, input logic en);
        @(posedge hclk);
        hresetn     <= 1'h0;
        sw_val      <= s;
        spec_cfg_en <= en;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        steps  = 0;
        stores = 0;
        num    = 1;
        den    = 1;
        repeat (3) @(posedge hclk);
    endtask
    function automatic int exp_vel(input logic [3:0] s, input logic d, input int lvl);
        int mag, v;
        if (s[2:1] == 2'h0) return 0;
        if (!s[2]) return s[0] ? -30 : 30;
        mag = s[1] ? lvl - 2048 : lvl;
        v = mag < 0 ? -mag : mag;
        if (v <= DZ_CNT) return 0;
        v = v * (s[0] ? 100 : 1000) * num / ((s[1] ? 2048 : 4095) * den);
        return (s[1] ? mag < 0 : d) ? -v : v;
    endfunction
    task automatic as_run(input logic prog, input logic ok, input logic idx);
        int n;
        bus(1'h1, OFF_CTLWORD, 32'h0);
        bus(1'h1, OFF_PROGCTL, {31'h0, prog});
        bus(1'h1, OFF_CTLWORD, 32'hF);
        bus(1'h1, OFF_CTLWORD, 32'h1F);
        n = 0;
        while (setup_run !== 1'h1 && n++ < 8) @(posedge hclk);
        check(setup_run, !prog);
        if (!prog) begin
            rchk(OFF_STATWORD, 32'h1004, 32'h4);
            @(posedge hclk);
            setup_res <= {1'h1, ok, idx, p};
            @(posedge hclk);
            setup_res.done <= 1'h0;
            repeat (2) @(posedge hclk);
            check(setup_run, 1'h0);
            rchk(OFF_STATWORD, 32'h1404, {19'h0, 1'h1, 1'h0, idx, 7'h0, 1'h1, 2'h0});
        end
    endtask

    initial begin
        int lv;
        logic dr;
        void'($urandom(32'h639f3fb5));
        restart(SW_SHIP, 1'h1);
        rchk(OFF_SCALE, 32'hFFFFFFFF, 32'h00010001);
        bus(1'h1, 8'h40, 32'hFFFFFFFF);
        rchk(8'h40, 32'hFFFFFFFF, 32'h0);
        for (int s = 0; s < 16; s++) begin
            restart(s[3:0], 1'h1);
            if (s == 12) begin
                bus(1'h1, OFF_SCALE, 32'h00020003);
                num = 3;
                den = 2;
            end
            sw_val      <= ~s[3:0];
            spec_cfg_en <= 1'h0;
            check(op_mode, s[2] ? OPM_VELOCITY : OPM_CLKDIR);
            check(closed_loop, s[3]);
            rchk(OFF_SPECIAL, 32'h17F, 32'h110 | s | (s[3] << 5));
            for (int k = 0; k < 4; k++) begin
                lv = k == 0 ? $urandom_range(4095) : (k == 1 ? DZ_CNT : (k == 2 ? 4095 : 2048 + DZ_CNT));
                dr = 1'($urandom);
                dms_op_src_inst.set_in(1'h1, dr, lv[11:0]);
                repeat (3) @(posedge hclk);
                check(vel_target, exp_vel(s[3:0], dr, lv));
            end
            rchk(OFF_VELTGT, 32'hFFFFFFFF, exp_vel(s[3:0], dr, lv));
            if (s[2:1] == 2'h0) begin
                dms_op_src_inst.set_in(1'h1, 1'h1, 12'h0);
                dms_op_src_inst.burst(5);
                repeat (3) @(posedge hclk);
                check(steps, 5);
                check(step_dir_out, 1'h1);
            end
            bus(1'h1, OFF_CTLWORD, 32'h0);
            check(op_enabled, 1'h1);
            dms_op_src_inst.set_in(1'h0, 1'h0, 12'h0);
            repeat (3) @(posedge hclk);
            check(op_enabled, 1'h0);
            check(op_mode, s[2] ? OPM_VELOCITY : OPM_CLKDIR);
        end
        restart(SW_SHIP, 1'h0);
        rchk(OFF_SPECIAL, 32'h110, 32'h0);
        p = $urandom;
        bus(1'h1, OFF_OPMODE, 32'hFE);
        bus(1'h1, OFF_CTLWORD, 32'h10);
        repeat (4) @(posedge hclk);
        check(setup_run, 1'h0);
        check(op_enabled, 1'h0);
        check(op_mode, OPM_AUTOSETUP);
        as_run(1'h0, 1'h1, 1'h1);
        check(stores, 1);
        rchk(OFF_PARAMS, 32'hFFFFFFFF, p);
        rchk(OFF_SPECIAL, 32'h40, 32'h40);
        as_run(1'h1, 1'h0, 1'h0);
        p = ~p;
        as_run(1'h0, 1'h0, 1'h0);
        check(stores, 1);
        rchk(OFF_PARAMS, 32'hFFFFFFFF, ~p);
        restart(SW_SHIP, 1'h0);
        rchk(OFF_SPECIAL, 32'h40, 32'h0);
        end_of_test();
    end
    initial begin
        #2000000;
        mismatches++;
        end_of_test();
    end
endmodule // test_dms_drive_mode

bind dms_drive_mode dms_drive_mode_chk dms_drive_mode_chk_inst (.hclk(hclk), .hresetn(hresetn), .op_in(op_in),
    .setup_res(setup_res), .setup_run(setup_run), .store_req(store_req), .op_enabled(op_enabled),
    .op_mode(op_mode), .closed_loop(closed_loop), .step_clk_out(step_clk_out),
    .step_dir_out(step_dir_out), .vel_target(vel_target));

`default_nettype wire
